/* design/liu_alert_pkg.sv */
// Shared constants and types for the host port, alert output and reset pin logic.
package liu_alert_pkg;

  // Register addresses on the eight-bit host address bus.
  localparam logic [7:0] CMD_ADDR   = 8'h00;
  localparam logic [7:0] IEN_ADDR   = 8'h01;
  localparam logic [7:0] ISR_ADDR   = 8'h02;

  // Values after reset, and the value read from an unmapped address.
  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [7:0] IEN_RESET  = 8'h00;
  localparam logic [7:0] ISR_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // One host bus sample: active-low strobes, address and write data.
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef enum logic {
    PORT_IDLE,
    PORT_DONE
  } port_state_t;

endpackage

/* design/liu_host_alert_and_reset.sv */
// Host parallel port with interrupt status, mask, alert output and reset pin handling.
`timescale 1ns/10ps
`default_nettype none
// Function
// - The data lines carry host write data in and register read data out; writes here use host_bus_in.wdata, and data_in is unused.
// - The alert output idles high and is driven low when an interrupt condition is pending.
// - Only interrupt conditions enabled by software may pull the alert low.
// - Reading the interrupt status clears the flags that the read returned.
// - After a clear the alert goes high only if no other enabled flag is pending.
// - The alert is a held level and stays low until the interrupt is serviced.
// - Pulsing the reset pin low returns every command register to its default.
// - An undriven reset pin reads as high through an internal pull-up.
// - The host data path is eight bits wide and bidirectional, with an eight-bit address.
// - An active-low ready output tells the host that a read or write has completed.

module liu_host_alert_and_reset #(
  parameter int NUM_SRC = 8
) (
  input  wire logic                       clock_in,
  input  wire logic                       sys_rst_in,
  input  wire liu_alert_pkg::host_req_t   host_bus_in,
  input  wire logic [7:0]                 data_in,
  output var  logic [7:0]                 data_out,
  output var  logic                       data_oe_out,
  output var  logic                       rdy_n_out,
  output var  logic                       alert_n_out,
  output var  logic                       alert_oe_out,
  input  wire logic                       reset_n_pin_in,
  input  wire logic                       reset_pin_oe_in,
  input  wire logic [NUM_SRC-1:0]         event_in,
  output var  logic [7:0]                 cmd_out
);

  ////////////////////////////////////////////////////////////////////////////////

  if (NUM_SRC < 1 || NUM_SRC > 8) begin : g_bad_width
    $error("NUM_SRC must lie between 1 and 8");
  end

  liu_alert_pkg::port_state_t state;
  liu_alert_pkg::port_state_t next_state;
  logic [7:0]                 cmd;
  logic [NUM_SRC-1:0]         ien;
  logic [NUM_SRC-1:0]         isr;
  logic [NUM_SRC-1:0]         next_isr;
  logic [NUM_SRC-1:0]         clear_mask;
  logic [7:0]                 rd_value;
  logic [7:0]                 isr_wide;
  logic [7:0]                 ien_wide;
  wire                        ext_rst_req;
  wire                        strobe;
  wire                        take;
  wire                        do_read;
  wire                        do_write;
  wire                        release_bus;
  wire                        pending;

  ////////////////////////////////////////////////////////////////////////////////

  // A floating pin is seen as high, so only an actively driven low requests a reset.
  assign ext_rst_req = reset_pin_oe_in & ~reset_n_pin_in;

  assign strobe      = ~host_bus_in.rd_n | ~host_bus_in.wr_n;
  assign take        = (state == liu_alert_pkg::PORT_IDLE) & ~host_bus_in.cs_n & strobe;
  // Read wins when both strobes are low, so a confused host never corrupts a register.
  assign do_read     = take & ~host_bus_in.rd_n;
  assign do_write    = take & host_bus_in.rd_n & ~host_bus_in.wr_n;
  assign release_bus = host_bus_in.cs_n | ~strobe;

  assign isr_wide    = 8'(isr);
  assign ien_wide    = 8'(ien);
  assign rd_value    = (host_bus_in.addr == liu_alert_pkg::CMD_ADDR) ? cmd :
                       (host_bus_in.addr == liu_alert_pkg::IEN_ADDR) ? ien_wide :
                       (host_bus_in.addr == liu_alert_pkg::ISR_ADDR) ? isr_wide :
                       liu_alert_pkg::UNMAPPED_RD;

  // Only the flags the host actually saw are cleared; a new event in the same cycle survives.
  assign clear_mask  = (do_read && host_bus_in.addr == liu_alert_pkg::ISR_ADDR) ? isr : '0;
  assign next_isr    = (isr & ~clear_mask) | event_in;
  // Flags latch even when masked; the enable only gates the alert, so masked sources can still be polled.
  assign pending     = |(isr & ien);

  always_comb begin
    next_state = state;
    unique case (state)
      liu_alert_pkg::PORT_IDLE: begin
        if (take) begin
          next_state = liu_alert_pkg::PORT_DONE;
        end
      end
      liu_alert_pkg::PORT_DONE: begin
        if (release_bus) begin
          next_state = liu_alert_pkg::PORT_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  // The port returns to idle only after a release, so one held strobe is one transfer.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= liu_alert_pkg::PORT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The reset pin acts synchronously so a glitch-free internal clock sees it like any input.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd <= liu_alert_pkg::CMD_RESET;
      ien <= NUM_SRC'(liu_alert_pkg::IEN_RESET);
      isr <= NUM_SRC'(liu_alert_pkg::ISR_RESET);
    end else if (ext_rst_req) begin
      cmd <= liu_alert_pkg::CMD_RESET;
      ien <= NUM_SRC'(liu_alert_pkg::IEN_RESET);
      isr <= NUM_SRC'(liu_alert_pkg::ISR_RESET);
    end else begin
      isr <= next_isr;
      if (do_write && host_bus_in.addr == liu_alert_pkg::CMD_ADDR) begin
        cmd <= host_bus_in.wdata;
      end
      if (do_write && host_bus_in.addr == liu_alert_pkg::IEN_ADDR) begin
        ien <= host_bus_in.wdata[NUM_SRC-1:0];
      end
    end
  end

  // Ready and the data drive stand until the host lets go, so a slow host cannot miss the answer.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdy_n_out   <= 1'b1;
      data_oe_out <= 1'b0;
      data_out    <= 8'h00;
    end else begin
      if (take) begin
        rdy_n_out <= 1'b0;
      end else if (release_bus) begin
        rdy_n_out <= 1'b1;
      end
      if (do_read) begin
        data_oe_out <= 1'b1;
        data_out    <= rd_value;
      end else if (release_bus) begin
        data_oe_out <= 1'b0;
      end
    end
  end

  // Open-drain style: the pin is pulled low while enabled, otherwise left to the pull-up.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alert_n_out  <= 1'b1;
      alert_oe_out <= 1'b0;
    end else begin
      alert_n_out  <= ~pending;
      alert_oe_out <= pending;
    end
  end

  assign cmd_out = cmd;

  ////////////////////////////////////////////////////////////////////////////////

  // The checks run on the logic's own clock and stay silent while the power-on reset is held.
  // Alert checks after a status read count two edges: one to clear the flag and one for the registered alert.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  a_read_drives_bus: assert property (do_read |=> data_oe_out && !rdy_n_out && data_out == $past(rd_value))
    else $error("read did not drive data and ready");
  a_write_stores_cmd: assert property (
    (do_write && !ext_rst_req && host_bus_in.addr == liu_alert_pkg::CMD_ADDR) |=> cmd == $past(host_bus_in.wdata))
    else $error("write to command register lost");
  a_alert_on_pending: assert property (pending |=> !alert_n_out && alert_oe_out)
    else $error("alert not asserted for pending source");
  a_masked_quiet: assert property ((ien == '0) [*2] |-> alert_n_out && !alert_oe_out)
    else $error("alert asserted with all sources masked");
  a_read_clears: assert property (
    (do_read && host_bus_in.addr == liu_alert_pkg::ISR_ADDR && event_in == '0) |=> isr == '0)
    else $error("status read did not clear flags");
  // A status read with no new event must let the alert go two edges later.
  a_release_after_read: assert property (
    (clear_mask != '0 && event_in == '0 && !ext_rst_req) |-> ##2 alert_n_out)
    else $error("alert not released after status read");
  a_alert_held: assert property ((!alert_n_out && pending && clear_mask == '0 && !ext_rst_req) |=> !alert_n_out)
    else $error("alert dropped before service");
  a_pin_reset: assert property (
    ext_rst_req |=> cmd == liu_alert_pkg::CMD_RESET && ien == '0 && isr == '0 ##1 alert_n_out)
    else $error("reset pin did not restore defaults");
  a_float_no_reset: assert property (
    (!reset_pin_oe_in && do_write && host_bus_in.addr == liu_alert_pkg::IEN_ADDR) |=>
      ien == $past(host_bus_in.wdata[NUM_SRC-1:0]))
    else $error("undriven reset pin acted as reset");
  a_ready_holds: assert property ((!rdy_n_out && !release_bus) |=> !rdy_n_out)
    else $error("ready dropped before host released strobe");
  a_no_cs_no_take: assert property (host_bus_in.cs_n |=> rdy_n_out)
    else $error("transfer completed without chip select");
  // Reading the status with a new enabled event in the same cycle must not release the alert.
  a_new_event_holds: assert property (
    (clear_mask != '0 && (event_in & ien) != '0 && !ext_rst_req) |-> ##2 !alert_n_out)
    else $error("alert released although a new event was pending");
  a_ready_release: assert property ((!rdy_n_out && release_bus) |=> rdy_n_out && !data_oe_out)
    else $error("ready or data drive not released");
  a_status_latches: assert property (
    (event_in != '0 && !ext_rst_req) |=> (isr & $past(event_in)) == $past(event_in))
    else $error("event lost from status");

  c_status_read: cover property (do_read && host_bus_in.addr == liu_alert_pkg::ISR_ADDR && isr != '0);
  c_alert_cycle: cover property ($fell(alert_n_out) ##[1:50] $rose(alert_n_out));
  c_pin_reset: cover property (ext_rst_req && cmd != liu_alert_pkg::CMD_RESET);
  c_set_and_clear: cover property ((clear_mask & event_in) != '0);
  c_held_event: cover property (clear_mask != '0 && (event_in & ien) != '0);

endmodule
`default_nettype wire

/* dv/liu_host_side.sv */
// Host-side pin model: resolves the data wires, the alert pull-up and the reset pin pull-up.
`timescale 1ns/10ps
`default_nettype none
module liu_host_side (
  input  wire logic       dev_oe_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic [7:0] host_data_in,
  input  wire logic       alert_oe_in,
  input  wire logic       rst_oe_in,
  input  wire logic       rst_lvl_in,
  output var  logic [7:0] bus_out,
  output var  logic       alert_wire_out,
  output var  logic       rst_wire_out
);
  // The host only drives the shared wires while the device has let go of them.
  assign bus_out        = dev_oe_in ? dev_data_in : host_data_in;
  assign alert_wire_out = alert_oe_in ? 1'b0 : 1'b1;
  assign rst_wire_out   = rst_oe_in ? rst_lvl_in : 1'b1;
endmodule
`default_nettype wire

/* dv/liu_host_alert_and_reset_bench.sv */
// Self-checking bench for the host port, alert output and reset pin logic.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %s exp %h got %h", n, e, a); end end
module liu_host_alert_and_reset_bench;
  logic                     clock_in = 1'b0, sys_rst_in = 1'b1, rst_oe = 1'b0, rst_lvl = 1'b1;
  logic                     data_oe, rdy_n, alert_n, alert_oe, rst_wire, alert_wire;
  logic [7:0]               data_out, cmd, bus, rd;
  logic [7:0]               ev = 8'h00;
  liu_alert_pkg::host_req_t hb = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, wdata: 8'h00};
  int                       n_tests = 0, n_mismatch = 0;
  liu_host_alert_and_reset #(.NUM_SRC(8)) u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .host_bus_in(hb),
    .data_in(bus), .data_out(data_out), .data_oe_out(data_oe), .rdy_n_out(rdy_n), .alert_n_out(alert_n),
    .alert_oe_out(alert_oe), .reset_n_pin_in(rst_wire), .reset_pin_oe_in(rst_oe), .event_in(ev), .cmd_out(cmd));
  liu_host_side u_host (.dev_oe_in(data_oe), .dev_data_in(data_out), .host_data_in(hb.wdata), .alert_oe_in(alert_oe),
    .rst_oe_in(rst_oe), .rst_lvl_in(rst_lvl), .bus_out(bus), .alert_wire_out(alert_wire), .rst_wire_out(rst_wire));
  initial forever #2.5 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic is_rd, input logic [7:0] a, input logic [7:0] w);
    int k;
    k = 0;
    @(negedge clock_in) hb = '{cs_n: 1'b0, rd_n: ~is_rd, wr_n: is_rd, addr: a, wdata: w};
    do begin @(posedge clock_in); #1; k++; end while (rdy_n !== 1'b0 && k < 20);
    rd = bus;
    `CHK("ready", 1'b0, rdy_n)
    `CHK("data drive", is_rd, data_oe)
    @(negedge clock_in) hb = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: a, wdata: w};
    @(negedge clock_in);
    `CHK("ready release", 1'b1, rdy_n)
    `CHK("data release", 1'b0, data_oe)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic t_reset;
    `CHK("alert", 1'b1, alert_wire)
    `CHK("cmd", liu_alert_pkg::CMD_RESET, cmd)
    acc(1'b1, liu_alert_pkg::ISR_ADDR, 8'h00);
    `CHK("status", liu_alert_pkg::ISR_RESET, rd)
    $display("reset test done");
  endtask
  task automatic t_write;
    acc(1'b0, liu_alert_pkg::CMD_ADDR, 8'hA5);
    `CHK("cmd", 8'hA5, cmd)
    @(negedge clock_in) hb = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b0, addr: liu_alert_pkg::CMD_ADDR, wdata: 8'h3C};
    wait_n(3);
    `CHK("no select ready", 1'b1, rdy_n)
    `CHK("no select cmd", 8'hA5, cmd)
    hb.wr_n = 1'b1;
    acc(1'b1, liu_alert_pkg::CMD_ADDR, 8'h00);
    `CHK("cmd read", 8'hA5, rd)
    acc(1'b1, 8'h7F, 8'h00);
    `CHK("unmapped", liu_alert_pkg::UNMAPPED_RD, rd)
    $display("write test done");
  endtask
  task automatic t_alert;
    @(negedge clock_in) ev = 8'h81;
    @(negedge clock_in) ev = 8'h00;
    wait_n(4);
    `CHK("masked alert", 1'b1, alert_wire)
    acc(1'b0, liu_alert_pkg::IEN_ADDR, 8'h01);
    wait_n(3);
    `CHK("alert", 1'b0, alert_wire)
    `CHK("alert level", 1'b0, alert_n)
    wait_n(8);
    `CHK("alert held", 1'b0, alert_wire)
    acc(1'b1, liu_alert_pkg::ISR_ADDR, 8'h00);
    `CHK("status", 8'h81, rd)
    `CHK("alert cleared", 1'b1, alert_wire)
    `CHK("alert level free", 1'b1, alert_n)
    // A level event that persists across the clearing read keeps its flag set.
    @(negedge clock_in) ev = 8'h01;
    acc(1'b1, liu_alert_pkg::ISR_ADDR, 8'h00);
    wait_n(2);
    `CHK("alert still", 1'b0, alert_wire)
    `CHK("status kept", 8'h01, rd)
    ev = 8'h00;
    acc(1'b1, liu_alert_pkg::ISR_ADDR, 8'h00);
    `CHK("status again", 8'h01, rd)
    wait_n(2);
    `CHK("alert free", 1'b1, alert_wire)
    $display("alert test done");
  endtask
  task automatic t_pin;
    acc(1'b0, liu_alert_pkg::CMD_ADDR, 8'h5A);
    @(negedge clock_in) ev = 8'h01;
    @(negedge clock_in) ev = 8'h00;
    rst_lvl = 1'b0;
    wait_n(3);
    `CHK("floating pin", 8'h5A, cmd)
    `CHK("pin alert before", 1'b0, alert_n)
    rst_oe = 1'b1;
    @(negedge clock_in) rst_oe = 1'b0;
    rst_lvl = 1'b1;
    wait_n(2);
    `CHK("pin cmd", liu_alert_pkg::CMD_RESET, cmd)
    `CHK("pin alert", 1'b1, alert_wire)
    acc(1'b1, liu_alert_pkg::IEN_ADDR, 8'h00);
    `CHK("pin enable", liu_alert_pkg::IEN_RESET, rd)
    $display("reset pin test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    $display("watchdog expired");
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clock_in);
    @(negedge clock_in) sys_rst_in = 1'b0;
    t_reset;
    t_write;
    t_alert;
    t_pin;
    end_of_test;
  end
endmodule
`default_nettype wire
